/* rtl/reset_seq_defines.svh */
`ifndef RESET_SEQ_DEFINES_SVH
`define RESET_SEQ_DEFINES_SVH

// register map (byte offsets on the plain register port)
`define ICSR_OFFSET        8'h00
`define CONFIG_OFFSET      8'h01
`define ICSR_RESET         8'h00
`define CONFIG_RESET       8'h00
// integrity status/control bit positions
`define BIT_AUX_IRQ_EN     0
`define BIT_AUX_FLAG       1
`define BIT_LV_FLAG        2
`define BIT_WDG_FLAG       4
// config register: read-only state, last cause and lvd threshold; clock and detector options come from pins
// timing
`define DELAY_SHORT        13'd256
`define DELAY_LONG         13'd4096
`define FETCH_CYCLES       2'd2
`define VECTOR_ADDR_HI     16'hFFFE
`define VECTOR_ADDR_LO     16'hFFFF
`define CLK_PERIOD_PS      4000
`define WDG_PULSE_NS       500
`define WDG_PULSE_CYC      ((`WDG_PULSE_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define PLL_STARTUP_NS     1000
`define PLL_STARTUP_CYC    ((`PLL_STARTUP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

/* rtl/reset_seq_pkg.sv */
package reset_seq_pkg;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_ACTIVE = 3'b001,
    ST_DELAY  = 3'b011,
    ST_PLL    = 3'b010,
    ST_FETCH  = 3'b110
  } seq_state_type;

  typedef enum logic [1:0] {
    CLK_RC   = 2'h0,
    CLK_EXT  = 2'h1,
    CLK_XTAL = 2'h2
  } clk_source_type;

  typedef enum logic [1:0] {
    LVL_LOW  = 2'h0,
    LVL_MED  = 2'h1,
    LVL_HIGH = 2'h2
  } lvd_level_type;

  typedef struct packed {
    clk_source_type clk_source;
    logic           pll_enable;
    logic           lvd_enable;
    lvd_level_type  lvd_level;
  } option_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_type;

endpackage : reset_seq_pkg

/* rtl/sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sync_state_type;

  sync_state_type st_r;
  sync_state_type st_nxt;

  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q = st_r.s2;
endmodule : sync2
`default_nettype wire

/* rtl/pulse_stretch.sv */
`timescale 1ns/1ps
`default_nettype none
module pulse_stretch #(
  parameter int CYCLES = 8
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic trig,
  output logic      busy
);
  localparam int CW = $clog2(CYCLES + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
  } stretch_state_type;

  stretch_state_type st_r;
  stretch_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (trig) begin
      st_nxt.cnt = CW'(CYCLES);
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - CW'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // min output width, restarts on a fresh trigger
  assign busy = (st_r.cnt != '0);
endmodule : pulse_stretch
`default_nettype wire

/* rtl/reset_sequence_manager.sv */
// What this block does
// - accept pin, low-voltage and watchdog resets
// - illegal opcode or prebyte also starts reset
// - all sources via pin, low through delay
// - fetch reset vector from top two bytes
// - phases: active, counted delay, vector fetch
// - delay 256 for RC/external, 4096 crystal
// - vector fetch takes exactly two cycles
// - pll enabled adds start-up delay
// - pin reset detected even while halted
// - pin is input and open-drain output
// - reset while detector reports low supply
// - watchdog drives pin low minimum width
// - detector threshold low, medium or high
// - detector enabled by nonvolatile option
// - aux comparator shown as read-only flag
// - aux detector works only with detector enabled
// - aux threshold crossing sets flag
// - aux irq needs flag, enable, mask clear
// - wait mode unchanged, aux irq wakes
// - halt freezes status, aux detector off
// - watchdog flag set; cleared by read or lv reset
// - lv flag survives external and watchdog resets
// - pending aux irq cleared on service entry
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_defines.svh"
module reset_sequence_manager
  import reset_seq_pkg::*;
#(
  parameter int DELAY_LONG  = 4096,
  parameter int DELAY_SHORT = 256,
  parameter int WDG_PULSE   = `WDG_PULSE_CYC,
  parameter int PLL_STARTUP = `PLL_STARTUP_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        reset_pin_in,
  output logic             reset_pin_out,
  output logic             reset_pin_oe_n,
  input  wire logic        lv_below,
  input  wire logic        aux_below,
  input  wire logic        wdg_underflow,
  input  wire logic        illegal_op,
  input  wire option_type  options,
  output logic [1:0]       lvd_threshold,
  input  wire logic        halt_mode,
  input  wire logic        wait_mode,
  input  wire logic        cc_irq_mask,
  input  wire logic        aux_irq_ack,
  input  wire reg_req_type reg_req,
  output logic [7:0]       reg_rdata,
  output logic             core_reset,
  output logic             pll_clk_gate,
  output logic             vector_fetch,
  output logic [15:0]      vector_addr,
  output logic             aux_irq,
  output logic             wake_req
);

  localparam int CW = 13;

  typedef struct packed {
    seq_state_type state;
    logic [CW-1:0] cnt;
    logic          pin_drive;
    logic          core_reset;
    logic          pll_gate;
    logic          fetch;
    logic [15:0]   vaddr;
    logic          wdg_flag;
    logic          lv_flag;
    logic          aux_flag;
    logic          aux_irq_en;
    logic          aux_pend;
    logic          aux_prev;
    logic          irq;
    logic          wake;
    logic [7:0]    rdata;
    logic [1:0]    lvd_thr;
    logic          last_wdg;
    logic          last_lv;
    logic [1:0]    drive_hist;
  } rsm_state_type;

  rsm_state_type st_r;
  rsm_state_type st_nxt;

  logic pin_low_s;
  logic lv_below_s;
  logic aux_below_s;
  logic wdg_busy;

  function automatic logic [CW-1:0] delay_for(input clk_source_type src);
    if (src == CLK_XTAL) begin
      delay_for = CW'(DELAY_LONG);
    end else begin
      delay_for = CW'(DELAY_SHORT);
    end
  endfunction : delay_for

  // pin and analog comparators are async: two flops before use
  sync2 #(
    .W(3)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       ({~reset_pin_in, lv_below, aux_below}),
    .q       ({pin_low_s, lv_below_s, aux_below_s})
  );

  pulse_stretch #(
    .CYCLES(WDG_PULSE)
  ) u_wdg_pulse (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .trig    (wdg_underflow),
    .busy    (wdg_busy)
  );

  logic lv_active;
  logic pin_src;
  logic any_src;
  logic aux_live;
  logic icsr_rd;

  always_comb begin
    lv_active = options.lvd_enable & lv_below_s;
    // own drive echoes back through the synchroniser: ignore it for two more cycles
    pin_src   = pin_low_s & ~st_r.pin_drive & ~(|st_r.drive_hist);
    // sync pin path clocked by sys_clk, which the core keeps running in halt
    any_src   = pin_src | lv_active | wdg_busy | wdg_underflow | illegal_op;
    aux_live  = options.lvd_enable & ~halt_mode;
    icsr_rd   = reg_req.rd & (reg_req.addr == `ICSR_OFFSET);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.lvd_thr = options.lvd_level;
    st_nxt.fetch = 1'b0;
    st_nxt.drive_hist = {st_r.drive_hist[0], st_r.pin_drive};

    unique case (st_r.state)
      ST_RUN: begin
        if (any_src) begin
          st_nxt.state = ST_ACTIVE;
          st_nxt.pin_drive = 1'b1;
          st_nxt.core_reset = 1'b1;
          st_nxt.pll_gate = 1'b0;
        end
      end
      ST_ACTIVE: begin
        // active phase lasts as long as a source other than the pin holds
        if (!any_src) begin
          st_nxt.state = ST_DELAY;
          st_nxt.cnt = delay_for(options.clk_source) - CW'(1);
        end
      end
      ST_DELAY: begin
        if (any_src) begin
          st_nxt.state = ST_ACTIVE;
        end else if (st_r.cnt == '0) begin
          if (options.pll_enable) begin
            st_nxt.state = ST_PLL;
            st_nxt.cnt = CW'(PLL_STARTUP - 1);
          end else begin
            st_nxt.state = ST_FETCH;
            st_nxt.cnt = CW'(`FETCH_CYCLES - 1);
            st_nxt.pin_drive = 1'b0;
            st_nxt.fetch = 1'b1;
            st_nxt.vaddr = `VECTOR_ADDR_HI;
          end
        end else begin
          st_nxt.cnt = st_r.cnt - CW'(1);
        end
      end
      ST_PLL: begin
        if (any_src) begin
          st_nxt.state = ST_ACTIVE;
        end else if (st_r.cnt == '0) begin
          st_nxt.state = ST_FETCH;
          st_nxt.cnt = CW'(`FETCH_CYCLES - 1);
          st_nxt.pin_drive = 1'b0;
          st_nxt.pll_gate = 1'b1;
          st_nxt.fetch = 1'b1;
          st_nxt.vaddr = `VECTOR_ADDR_HI;
        end else begin
          st_nxt.cnt = st_r.cnt - CW'(1);
        end
      end
      ST_FETCH: begin
        if (any_src) begin
          st_nxt.state = ST_ACTIVE;
          st_nxt.pin_drive = 1'b1;
          st_nxt.pll_gate = 1'b0;
        end else if (st_r.cnt == '0) begin
          st_nxt.state = ST_RUN;
          st_nxt.core_reset = 1'b0;
        end else begin
          st_nxt.cnt = st_r.cnt - CW'(1);
          st_nxt.fetch = 1'b1;
          st_nxt.vaddr = `VECTOR_ADDR_LO;
        end
      end
      default: begin
        st_nxt.state = ST_ACTIVE;
        st_nxt.pin_drive = 1'b1;
        st_nxt.core_reset = 1'b1;
      end
    endcase

    if (!options.pll_enable) begin
      st_nxt.pll_gate = ~st_nxt.core_reset | (st_nxt.state == ST_FETCH);
    end

    // cause latching: lv wins over watchdog, both rewritten only when a reset starts from run
    if (st_r.state == ST_RUN && any_src) begin
      st_nxt.last_lv  = lv_active;
      st_nxt.last_wdg = wdg_underflow & ~lv_active;
    end

    // status register updates, including read clears; halt freezes all of them
    if (!halt_mode) begin
      if (icsr_rd) begin
        st_nxt.wdg_flag = 1'b0;
        st_nxt.lv_flag = 1'b0;
      end
      if (wdg_underflow) begin
        st_nxt.wdg_flag = 1'b1;
      end
      if (lv_active) begin
        st_nxt.lv_flag = 1'b1;
        st_nxt.wdg_flag = 1'b0;
      end
      if (reg_req.wr && reg_req.addr == `ICSR_OFFSET) begin
        st_nxt.aux_irq_en = reg_req.wdata[`BIT_AUX_IRQ_EN];
      end
      st_nxt.aux_flag = aux_live & aux_below_s;
      st_nxt.aux_prev = st_nxt.aux_flag;
      if (aux_irq_ack) begin
        st_nxt.aux_pend = 1'b0;
      end
      if (st_nxt.aux_flag && !st_r.aux_prev) begin
        st_nxt.aux_pend = 1'b1;
      end
      if (!aux_live) begin
        st_nxt.aux_pend = 1'b0;
      end
    end

    st_nxt.irq = st_nxt.aux_pend & st_nxt.aux_irq_en & ~cc_irq_mask;
    // wake only from wait, never from halt
    st_nxt.wake = st_nxt.aux_pend & st_nxt.aux_irq_en & wait_mode & ~halt_mode;

    st_nxt.rdata = 8'h00;
    if (reg_req.rd) begin
      unique case (reg_req.addr)
        `ICSR_OFFSET: begin
          st_nxt.rdata[`BIT_WDG_FLAG]   = st_r.wdg_flag;
          st_nxt.rdata[`BIT_LV_FLAG]    = st_r.lv_flag;
          st_nxt.rdata[`BIT_AUX_FLAG]   = st_r.aux_flag;
          st_nxt.rdata[`BIT_AUX_IRQ_EN] = st_r.aux_irq_en;
        end
        `CONFIG_OFFSET: begin
          st_nxt.rdata = {1'b0, st_r.state, st_r.last_wdg, st_r.last_lv, st_r.lvd_thr};
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st_r <= '0;
      st_r.state <= ST_ACTIVE;
      st_r.pin_drive <= 1'b1;
      st_r.core_reset <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    reset_pin_out  = 1'b0;
    reset_pin_oe_n = ~st_r.pin_drive;
    lvd_threshold  = st_r.lvd_thr;
    reg_rdata      = st_r.rdata;
    core_reset     = st_r.core_reset;
    pll_clk_gate   = st_r.pll_gate;
    vector_fetch   = st_r.fetch;
    vector_addr    = st_r.vaddr;
    aux_irq        = st_r.irq;
    wake_req       = st_r.wake;
  end

endmodule : reset_sequence_manager
`default_nettype wire

/* tb/reset_seq_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_seq_sva
  import reset_seq_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        reset_pin_oe_n,
  input wire logic        lv_below,
  input wire logic        wdg_underflow,
  input wire logic        illegal_op,
  input wire option_type  options,
  input wire logic        cc_irq_mask,
  input wire logic        wait_mode,
  input wire logic        core_reset,
  input wire logic        vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic        aux_irq,
  input wire logic        wake_req
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  fetch_pair_a: assert property (
    $rose(vector_fetch) |-> vector_addr == 16'hFFFE ##1 vector_fetch && vector_addr == 16'hFFFF
    ##1 !vector_fetch) else $error("vector fetch not two cycles");
  pin_low_a: assert property (
    core_reset && !vector_fetch |-> !reset_pin_oe_n) else $error("pin released early");
  lv_reset_a: assert property (
    options.lvd_enable && lv_below |-> ##[1:4] core_reset) else $error("no low supply reset");
  wdg_width_a: assert property (
    wdg_underflow |=> !reset_pin_oe_n [*4]) else $error("watchdog pulse too short");
  illegal_rst_a: assert property (
    illegal_op |=> !reset_pin_oe_n) else $error("illegal opcode ignored");
  irq_mask_a: assert property (
    cc_irq_mask |=> !aux_irq) else $error("irq despite mask");
  delay_min_a: assert property (
    $rose(vector_fetch) |-> $past(reset_pin_oe_n, 8) == 1'b0) else $error("delay too short");
  wait_wake_a: assert property (
    wait_mode && aux_irq |-> ##[0:2] wake_req) else $error("no wake from wait");
  fetch_c: cover property ($rose(vector_fetch));
  wdg_c: cover property (wdg_underflow);
  wake_c: cover property (wait_mode && aux_irq);
endmodule : reset_seq_sva
bind reset_sequence_manager reset_seq_sva reset_seq_sva_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .reset_pin_oe_n(reset_pin_oe_n), .lv_below(lv_below),
  .wdg_underflow(wdg_underflow), .illegal_op(illegal_op), .options(options),
  .cc_irq_mask(cc_irq_mask), .wait_mode(wait_mode), .core_reset(core_reset),
  .vector_fetch(vector_fetch), .vector_addr(vector_addr), .aux_irq(aux_irq), .wake_req(wake_req));
`default_nettype wire

/* tb/ext_reset_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ext_reset_model (
  input  wire logic pull_req,
  input  wire logic oe_n,
  input  wire logic dout,
  output logic      pin
);
  // weak pull-up: any low driver wins over it
  assign pin = ((!oe_n && !dout) || pull_req) ? 1'b0 : 1'b1;
endmodule : ext_reset_model
`default_nettype wire

/* tb/reset_sequence_manager_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_sequence_manager_tb;
  import reset_seq_pkg::*;
  logic sys_clk = 0, rst_n = 0, lv_below = 0, aux_below = 0, wdg_underflow = 0, illegal_op = 0;
  logic halt_mode = 0, wait_mode = 0, cc_irq_mask = 0, aux_irq_ack = 0, press = 0;
  option_type  options = '{CLK_RC, 1'b0, 1'b1, LVL_MED};
  reg_req_type reg_req = '0;
  logic        pin_level, reset_pin_out, reset_pin_oe_n, core_reset, pll_clk_gate;
  logic        vector_fetch, aux_irq, wake_req;
  logic [1:0]  lvd_threshold;
  logic [7:0]  reg_rdata;
  logic [15:0] vector_addr;
  int          miscompares = 0, cmp_count = 0, n;
  always #2 sys_clk = ~sys_clk;
  // short counts keep the run brief
  reset_sequence_manager #(.DELAY_LONG(16), .DELAY_SHORT(8), .WDG_PULSE(4), .PLL_STARTUP(5))
  reset_sequence_manager_i (.sys_clk(sys_clk), .rst_n(rst_n), .reset_pin_in(pin_level),
    .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n), .lv_below(lv_below),
    .aux_below(aux_below), .wdg_underflow(wdg_underflow), .illegal_op(illegal_op),
    .options(options), .lvd_threshold(lvd_threshold), .halt_mode(halt_mode),
    .wait_mode(wait_mode), .cc_irq_mask(cc_irq_mask), .aux_irq_ack(aux_irq_ack),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .core_reset(core_reset),
    .pll_clk_gate(pll_clk_gate), .vector_fetch(vector_fetch), .vector_addr(vector_addr),
    .aux_irq(aux_irq), .wake_req(wake_req));
  ext_reset_model ext_reset_model_i (.pull_req(press), .oe_n(reset_pin_oe_n),
    .dout(reset_pin_out), .pin(pin_level));
  task automatic summarize();
    $display("checks %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic check(input string name, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : cyc
  task automatic wr(input logic [7:0] a, d);
    cyc(1);
    reg_req <= '{a, d, 1'b1, 1'b0};
    cyc(1);
    reg_req <= '0;
  endtask : wr
  task automatic rd(input logic [7:0] a, m, e);
    cyc(1);
    reg_req <= '{a, 8'h00, 1'b0, 1'b1};
    cyc(1);
    reg_req <= '0;
    @(negedge sys_clk);
    check("rdata", {8'h00, e}, {8'h00, reg_rdata & m});
    cyc(1);
  endtask : rd
  // bounded wait for the fetch, then the two fetch cycles
  task automatic seq(output int k);
    logic low_ok;
    low_ok = 1'b1;
    k = 0;
    while (vector_fetch !== 1'b1) begin
      cyc(1);
      k++;
      if (k > 3 && vector_fetch !== 1'b1 && pin_level !== 1'b0) low_ok = 1'b0;
      if (k > 400) begin
        miscompares++;
        summarize();
      end
    end
    check("pin low", 16'h1, {15'h0, low_ok});
    check("addr hi", 16'hFFFE, vector_addr);
    cyc(1);
    check("addr lo", 16'hFFFF, vector_addr);
    cyc(1);
    check("fetch end", 16'h0, {15'h0, vector_fetch});
    check("core run", 16'h0, {15'h0, core_reset});
    check("clk gate", 16'h1, {15'h0, pll_clk_gate});
  endtask : seq
  task automatic t_nolvd();
    cyc(1);
    options.lvd_enable <= 1'b0;
    aux_below <= 1'b1;
    lv_below <= 1'b1;
    cyc(6);
    check("lv off", 16'h0, {15'h0, core_reset});
    check("aux irq off", 16'h0, {15'h0, aux_irq});
    rd(8'h00, 8'h02, 8'h00);
    aux_below <= 1'b0;
    lv_below <= 1'b0;
    options.lvd_enable <= 1'b1;
    cyc(4);
    $display("test nolvd done");
  endtask : t_nolvd
  task automatic run_illegal(input option_type o, output int k);
    cyc(1);
    options <= o;
    illegal_op <= 1'b1;
    cyc(1);
    illegal_op <= 1'b0;
    seq(k);
  endtask : run_illegal
  task automatic lv_reset();
    cyc(1);
    lv_below <= 1'b1;
    cyc(4);
    lv_below <= 1'b0;
    seq(n);
  endtask : lv_reset
  task automatic wdg_reset();
    cyc(1);
    wdg_underflow <= 1'b1;
    cyc(1);
    wdg_underflow <= 1'b0;
    seq(n);
  endtask : wdg_reset
  task automatic t_delay();
    int rc, ext, xt, pl;
    run_illegal('{CLK_RC, 1'b0, 1'b1, LVL_MED}, rc);
    run_illegal('{CLK_EXT, 1'b0, 1'b1, LVL_MED}, ext);
    run_illegal('{CLK_XTAL, 1'b0, 1'b1, LVL_MED}, xt);
    run_illegal('{CLK_RC, 1'b1, 1'b1, LVL_MED}, pl);
    check("ext delay", 16'(rc), 16'(ext));
    check("xtal delay", 16'(rc + 8), 16'(xt));
    check("pll delay", 16'(rc + 5), 16'(pl));
    for (int i = 0; i < 3; i++) begin
      cyc(1);
      options.lvd_level <= lvd_level_type'(i);
      cyc(2);
      check("threshold", 16'(i), {14'h0, lvd_threshold});
    end
    $display("test delay done");
  endtask : t_delay
  task automatic t_flags();
    lv_reset();
    wdg_reset();
    rd(8'h00, 8'h14, 8'h14);
    rd(8'h00, 8'h14, 8'h00);
    wdg_reset();
    lv_reset();
    rd(8'h00, 8'h14, 8'h04);
    cyc(1);
    halt_mode <= 1'b1;
    press <= 1'b1;
    cyc(3);
    halt_mode <= 1'b0;
    press <= 1'b0;
    seq(n);
    rd(8'h00, 8'h14, 8'h00);
    $display("test flags done");
  endtask : t_flags
  task automatic t_aux();
    wr(8'h00, 8'h01);
    cyc(1);
    aux_below <= 1'b1;
    cyc(5);
    check("irq set", 16'h1, {15'h0, aux_irq});
    rd(8'h00, 8'h03, 8'h03);
    cc_irq_mask <= 1'b1;
    cyc(3);
    check("irq masked", 16'h0, {15'h0, aux_irq});
    cc_irq_mask <= 1'b0;
    wait_mode <= 1'b1;
    cyc(3);
    check("wake", 16'h1, {15'h0, wake_req});
    aux_irq_ack <= 1'b1;
    cyc(1);
    aux_irq_ack <= 1'b0;
    wait_mode <= 1'b0;
    cyc(3);
    check("irq ack", 16'h0, {15'h0, aux_irq});
    halt_mode <= 1'b1;
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h01, 8'h01);
    halt_mode <= 1'b0;
    aux_below <= 1'b0;
    cyc(5);
    rd(8'h00, 8'h02, 8'h00);
    rd(8'h7F, 8'hFF, 8'h00);
    $display("test aux done");
  endtask : t_aux
  initial begin
    cyc(3);
    rst_n <= 1'b1;
    seq(n);
    t_delay();
    t_flags();
    t_aux();
    t_nolvd();
    summarize();
  end
endmodule : reset_sequence_manager_tb
`default_nettype wire
